/* File: rtl/csr_alu.sv */
/*
 Arithmetic unit for the core special registers: results and flags for
 add, subtract, multiply, divide, decimal adjust and compare.
 Assumes operands stable in the cycle the operation is committed.
*/
`timescale 1ns/10ps
`default_nettype none
module csr_alu (
   input  wire csr_pkg::csr_op_t op_i,
   input  wire logic [7:0]       acc_i,
   input  wire logic [7:0]       opnd_i,
   input  wire logic [7:0]       sec_i,
   input  wire logic             cy_i,
   input  wire logic             ac_i,
   output logic [7:0]            res_a_o,
   output logic [7:0]            res_b_o,
   output logic                  cy_o,
   output logic                  ac_o,
   output logic                  ov_o,
   output logic                  cy_we_o,
   output logic                  ac_we_o,
   output logic                  ov_we_o
);
   import csr_pkg::*;

   wire logic       cin     = (op_i == CSR_OP_ADDC || op_i == CSR_OP_SUBB) ? cy_i : 1'b0;
   wire logic [4:0] add_lo  = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]} + {4'b0000, cin};
   wire logic [7:0] add_c7  = {1'b0, acc_i[6:0]} + {1'b0, opnd_i[6:0]} + {7'h00, cin};
   wire logic [8:0] add_all = {1'b0, acc_i} + {1'b0, opnd_i} + {8'h00, cin};
   wire logic [4:0] sub_lo  = {1'b0, acc_i[3:0]} - {1'b0, opnd_i[3:0]} - {4'b0000, cin};
   wire logic [7:0] sub_c7  = {1'b0, acc_i[6:0]} - {1'b0, opnd_i[6:0]} - {7'h00, cin};
   wire logic [8:0] sub_all = {1'b0, acc_i} - {1'b0, opnd_i} - {8'h00, cin};
   wire logic [15:0] prod   = acc_i * sec_i;
   wire logic        div0   = (sec_i == 8'h00);
   wire logic [7:0]  quo    = div0 ? 8'h00 : acc_i / sec_i;
   wire logic [7:0]  rem    = div0 ? 8'h00 : acc_i % sec_i;
   wire logic        da_lo  = (acc_i[3:0] > 4'h9) || ac_i;
   wire logic [8:0]  da_s1  = {1'b0, acc_i} + (da_lo ? 9'h006 : 9'h000);
   wire logic        da_hi  = (da_s1[7:4] > 4'h9) || cy_i || da_s1[8];
   wire logic [8:0]  da_s2  = da_s1 + (da_hi ? 9'h060 : 9'h000);

   always_comb begin
      res_a_o = acc_i;
      res_b_o = sec_i;
      cy_o = cy_i;
      ac_o = ac_i;
      ov_o = 1'b0;
      cy_we_o = 1'b0;
      ac_we_o = 1'b0;
      ov_we_o = 1'b0;
      unique case (op_i)
         CSR_OP_ADD, CSR_OP_ADDC: begin
            res_a_o = add_all[7:0];
            cy_o = add_all[8];
            ac_o = add_lo[4];
            ov_o = add_all[8] ^ add_c7[7];
            {cy_we_o, ac_we_o, ov_we_o} = 3'b111;
         end
         CSR_OP_SUBB: begin
            res_a_o = sub_all[7:0];
            cy_o = sub_all[8];
            ac_o = sub_lo[4];
            ov_o = sub_all[8] ^ sub_c7[7];
            {cy_we_o, ac_we_o, ov_we_o} = 3'b111;
         end
         CSR_OP_MUL: begin
            res_a_o = prod[7:0];
            res_b_o = prod[15:8];
            cy_o = 1'b0;
            ov_o = (prod > {8'h00, PROD_LIMIT});
            {cy_we_o, ov_we_o} = 2'b11;
         end
         CSR_OP_DIV: begin
            res_a_o = quo;
            res_b_o = rem;
            cy_o = 1'b0;
            ov_o = div0;
            {cy_we_o, ov_we_o} = 2'b11;
         end
         CSR_OP_DA: begin
            res_a_o = da_s2[7:0];
            cy_o = cy_i | da_s2[8] | da_hi;
            cy_we_o = 1'b1;
         end
         CSR_OP_CJNE: begin
            cy_o = (acc_i < opnd_i);
            cy_we_o = 1'b1;
         end
         default: begin
         end
      endcase
   end
endmodule
`default_nettype wire

/* File: rtl/csr_core_regs.sv */
/*
 Core special registers: accumulator, secondary register, stack pointer,
 two data pointers with select, and the program status word.
 Assumes the execution unit issues one operation or one register access
 per cycle; register reads return data one cycle after the strobe.
*/
// The strobed register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module csr_core_regs (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [7:0]       addr_i,
   input  wire logic [7:0]       wdata_i,
   input  wire logic             wr_i,
   input  wire logic             rd_i,
   output logic [7:0]            rdata_o,
   input  wire logic             bit_we_i,
   input  wire logic [2:0]       bit_sel_i,
   input  wire logic             bit_val_i,
   output logic                  acc_bit_o,
   input  wire csr_pkg::csr_op_t op_i,
   input  wire logic [7:0]       opnd_i,
   output logic [7:0]            acc_o,
   output logic [7:0]            sec_o,
   output logic [7:0]            stack_pointer_o,
   output logic [7:0]            stack_addr_o,
   output logic                  stack_we_o,
   output logic [7:0]            stack_wdata_o,
   output logic [15:0]           data_pointer_o,
   output logic [7:0]            program_status_word_o,
   input  wire logic [2:0]       work_reg_i,
   output logic [7:0]            work_reg_addr_o
);
   import csr_pkg::*;

   logic [7:0]  acc_reg, sec_reg, sp_reg, psw_reg, aux_reg;
   logic [15:0] ptr0_reg, ptr1_reg;
   logic [7:0]  rdata_reg, stack_addr_reg, stack_wdata_reg;
   logic        stack_we_reg;
   logic [7:0]  res_a, res_b;
   logic        cy_n, ac_n, ov_n, cy_we, ac_we, ov_we;

   csr_alu u_alu (
      .op_i    (op_i),
      .acc_i   (acc_reg),
      .opnd_i  (opnd_i),
      .sec_i   (sec_reg),
      .cy_i    (psw_reg[BIT_CARRY]),
      .ac_i    (psw_reg[BIT_AUXC]),
      .res_a_o (res_a),
      .res_b_o (res_b),
      .cy_o    (cy_n),
      .ac_o    (ac_n),
      .ov_o    (ov_n),
      .cy_we_o (cy_we),
      .ac_we_o (ac_we),
      .ov_we_o (ov_we)
   );

   // Register decode
   wire logic psel     = aux_reg[BIT_PSEL];
   wire logic wr_acc   = wr_i && addr_i == ADDR_ACC;
   wire logic wr_sec   = wr_i && addr_i == ADDR_MULDIV;
   wire logic wr_sp    = wr_i && addr_i == ADDR_STACK;
   wire logic wr_lo    = wr_i && addr_i == ADDR_PTR_LO;
   wire logic wr_hi    = wr_i && addr_i == ADDR_PTR_HI;
   wire logic wr_psw   = wr_i && addr_i == ADDR_STATUS;
   wire logic wr_aux   = wr_i && addr_i == ADDR_AUX;
   wire logic alu_a    = op_i inside {CSR_OP_ADD, CSR_OP_ADDC, CSR_OP_SUBB,
                                      CSR_OP_MUL, CSR_OP_DIV, CSR_OP_DA};
   wire logic alu_b    = op_i inside {CSR_OP_MUL, CSR_OP_DIV};
   wire logic [15:0] ptr_act = psel ? ptr1_reg : ptr0_reg;

   // Accumulator next value with single-bit writes
   logic [7:0] acc_next;
   always_comb begin
      acc_next = acc_reg;
      if (alu_a) begin
         acc_next = res_a;
      end else if (wr_acc) begin
         acc_next = wdata_i;
      end else if (bit_we_i) begin
         acc_next[bit_sel_i] = bit_val_i;
      end
   end

   wire logic [7:0] sec_next = alu_b ? res_b : (wr_sec ? wdata_i : sec_reg);

   wire logic [7:0] sp_inc  = sp_reg + 8'h01;
   wire logic [7:0] sp_next = (op_i == CSR_OP_PUSH) ? sp_inc :
                              (op_i == CSR_OP_POP) ? sp_reg - 8'h01 :
                              (wr_sp ? wdata_i : sp_reg);

   wire logic [15:0] ptr_wr  = wr_lo ? {ptr_act[15:8], wdata_i} :
                               (wr_hi ? {wdata_i, ptr_act[7:0]} : ptr_act);
   wire logic        ptr_upd = wr_lo || wr_hi;

   // Status word: parity is never stored from software
   logic [7:0] psw_next;
   always_comb begin
      psw_next = wr_psw ? wdata_i : psw_reg;
      if (cy_we) begin
         psw_next[BIT_CARRY] = cy_n;
      end
      if (ac_we) begin
         psw_next[BIT_AUXC] = ac_n;
      end
      if (ov_we) begin
         psw_next[BIT_OVF] = ov_n;
      end
      psw_next[BIT_PARITY] = ^acc_next;
   end

   wire logic [1:0] bank = {psw_reg[BIT_BANKHI], psw_reg[BIT_BANKLO]};

   logic [7:0] rd_mux;
   always_comb begin
      unique case (addr_i)
         ADDR_ACC:    rd_mux = acc_reg;
         ADDR_MULDIV: rd_mux = sec_reg;
         ADDR_STACK:  rd_mux = sp_reg;
         ADDR_PTR_LO: rd_mux = ptr_act[7:0];
         ADDR_PTR_HI: rd_mux = ptr_act[15:8];
         ADDR_STATUS: rd_mux = psw_reg;
         ADDR_AUX:    rd_mux = {7'h00, aux_reg[BIT_PSEL]};
         default:     rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_reg  <= RST_ZERO;
         sec_reg  <= RST_ZERO;
         psw_reg  <= RST_ZERO;
         ptr0_reg <= {RST_ZERO, RST_ZERO};
         ptr1_reg <= {RST_ZERO, RST_ZERO};
         aux_reg  <= RST_ZERO;
         sp_reg   <= RST_STACK;
      end else begin
         acc_reg <= acc_next;
         sec_reg <= sec_next;
         psw_reg <= psw_next;
         sp_reg  <= sp_next;
         if (wr_aux) begin
            aux_reg <= {7'h00, wdata_i[BIT_PSEL]};
         end
         if (ptr_upd && !psel) begin
            ptr0_reg <= ptr_wr;
         end
         if (ptr_upd && psel) begin
            ptr1_reg <= ptr_wr;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg       <= 8'h00;
         stack_we_reg    <= 1'b0;
         stack_addr_reg  <= 8'h00;
         stack_wdata_reg <= 8'h00;
      end else begin
         rdata_reg       <= rd_i ? rd_mux : 8'h00;
         stack_we_reg    <= (op_i == CSR_OP_PUSH);
         stack_addr_reg  <= sp_inc;
         stack_wdata_reg <= opnd_i;
      end
   end

   assign rdata_o               = rdata_reg;
   assign acc_bit_o             = acc_reg[bit_sel_i];
   assign acc_o                 = acc_reg;
   assign sec_o                 = sec_reg;
   assign stack_pointer_o       = sp_reg;
   assign stack_addr_o          = stack_addr_reg;
   assign stack_we_o            = stack_we_reg;
   assign stack_wdata_o         = stack_wdata_reg;
   assign data_pointer_o        = ptr_act;
   assign program_status_word_o = psw_reg;
   assign work_reg_addr_o       = {3'b000, bank, work_reg_i};

   // Checks
   sequence s_push;
      op_i == CSR_OP_PUSH;
   endsequence
   sequence s_store(logic [7:0] a);
      stack_we_o && stack_addr_o == a && stack_pointer_o == a;
   endsequence

   a_reset_values: assert property (@(posedge clk_i) rst_i |=>
      acc_o == 8'h00 && sec_o == 8'h00 && program_status_word_o == 8'h00
      && data_pointer_o == 16'h0000)
      else $error("reset values wrong");
   a_stack_reset: assert property (@(posedge clk_i) rst_i |=> stack_pointer_o == 8'h07)
      else $error("stack pointer reset wrong");
   a_push_order: assert property (@(posedge clk_i) disable iff (rst_i)
      s_push |=> s_store($past(stack_pointer_o) + 8'h01))
      else $error("push not pre-increment");
   a_parity_even: assert property (@(posedge clk_i) disable iff (rst_i)
      program_status_word_o[0] == ^acc_o)
      else $error("parity flag wrong");
   a_muldiv_carry: assert property (@(posedge clk_i) disable iff (rst_i)
      (op_i == CSR_OP_MUL || op_i == CSR_OP_DIV) |=> !program_status_word_o[7])
      else $error("mul/div carry not cleared");
   a_mul_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
      op_i == CSR_OP_MUL |=> program_status_word_o[2] == ($past(acc_o) * $past(sec_o) > 255))
      else $error("mul overflow wrong");
   a_div_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      op_i == CSR_OP_DIV |=> program_status_word_o[2] == ($past(sec_o) == 8'h00))
      else $error("div overflow wrong");
   a_add_carry: assert property (@(posedge clk_i) disable iff (rst_i)
      op_i == CSR_OP_ADD |=> program_status_word_o[7]
         == (({1'b0, $past(acc_o)} + {1'b0, $past(opnd_i)}) > 9'h0ff))
      else $error("add carry wrong");
   a_add_auxc: assert property (@(posedge clk_i) disable iff (rst_i)
      op_i == CSR_OP_ADD |=> program_status_word_o[6]
         == (({1'b0, $past(acc_o[3:0])} + {1'b0, $past(opnd_i[3:0])}) > 5'h0f))
      else $error("aux carry wrong");
   a_cjne_carry: assert property (@(posedge clk_i) disable iff (rst_i)
      op_i == CSR_OP_CJNE |=> program_status_word_o[7] == ($past(acc_o) < $past(opnd_i)))
      else $error("compare carry wrong");
   a_bank_map: assert property (@(posedge clk_i) disable iff (rst_i)
      work_reg_addr_o == {program_status_word_o[4:3], 3'b000} + {5'h00, work_reg_i})
      else $error("bank mapping wrong");
   a_ptr_select: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_lo && !wr_aux ##1 !wr_aux |-> data_pointer_o[7:0] == $past(wdata_i))
      else $error("pointer write lost");
endmodule
`default_nettype wire

/* File: rtl/csr_pkg.sv */
/*
 Constants for the core special registers: register offsets, reset values,
 status word field positions, ALU operation codes and BCD and product limits.
 Assumes a byte-wide CPU core driving one synchronous clock domain.
*/
package csr_pkg;
   localparam logic [7:0] ADDR_STACK   = 8'h81;
   localparam logic [7:0] ADDR_PTR_LO  = 8'h82;
   localparam logic [7:0] ADDR_PTR_HI  = 8'h83;
   localparam logic [7:0] ADDR_AUX     = 8'ha2;
   localparam logic [7:0] ADDR_STATUS  = 8'hd0;
   localparam logic [7:0] ADDR_ACC     = 8'he0;
   localparam logic [7:0] ADDR_MULDIV  = 8'hf0;

   localparam logic [7:0] RST_STACK    = 8'h07;
   localparam logic [7:0] RST_ZERO     = 8'h00;

   localparam int BIT_CARRY  = 7;
   localparam int BIT_AUXC   = 6;
   localparam int BIT_USER0  = 5;
   localparam int BIT_BANKHI = 4;
   localparam int BIT_BANKLO = 3;
   localparam int BIT_OVF    = 2;
   localparam int BIT_USER1  = 1;
   localparam int BIT_PARITY = 0;
   localparam int BIT_PSEL   = 0;

   localparam logic [7:0] BCD_LIMIT    = 8'h99;
   localparam logic [7:0] PROD_LIMIT   = 8'hff;

   typedef enum logic [3:0] {
      CSR_OP_NONE = 4'b0000,
      CSR_OP_ADD  = 4'b0001,
      CSR_OP_ADDC = 4'b0010,
      CSR_OP_SUBB = 4'b0011,
      CSR_OP_MUL  = 4'b0100,
      CSR_OP_DIV  = 4'b0101,
      CSR_OP_DA   = 4'b0110,
      CSR_OP_CJNE = 4'b0111,
      CSR_OP_PUSH = 4'b1000,
      CSR_OP_POP  = 4'b1001
   } csr_op_t;
endpackage

/* File: verif/cpu_core_special_registers_test.sv */
/*
 Self-checking bench for csr_core_regs: register bus, bit writes, flags,
 stack, banks and pointers.
 Assumes the csr_pkg package and a 200 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cpu_core_special_registers_test;
   import csr_pkg::*;
   logic        clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, bit_we_i = 0, bit_val_i = 0;
   logic [7:0]  addr_i = 0, wdata_i = 0, opnd_i = 0;
   logic [2:0]  bit_sel_i = 0, work_reg_i = 0;
   csr_op_t     op_i = CSR_OP_NONE;
   logic [7:0]  rdata_o, acc_o, sec_o, stack_pointer_o, stack_addr_o, stack_wdata_o;
   logic [7:0]  program_status_word_o, work_reg_addr_o;
   logic        acc_bit_o, stack_we_o, rd_pend = 0;
   logic [15:0] data_pointer_o;
   logic [31:0] seed = 32'h9dd8_51e2;
   logic [7:0]  exp_q[$];
   logic [7:0]  ra[8] = '{ADDR_ACC, ADDR_MULDIV, ADDR_STACK, ADDR_PTR_LO, ADDR_PTR_HI,
                          ADDR_STATUS, ADDR_AUX, 8'h90};
   int          bad_count = 0, checked = 0;

   csr_core_regs csr_core_regs_i (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .bit_we_i, .bit_sel_i, .bit_val_i, .acc_bit_o, .op_i, .opnd_i, .acc_o, .sec_o,
      .stack_pointer_o, .stack_addr_o, .stack_we_o, .stack_wdata_o, .data_pointer_o,
      .program_status_word_o, .work_reg_i, .work_reg_addr_o);

   always #2.5 clk_i = ~clk_i;

   function automatic logic [7:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c1_1db7 : 32'h0000_0000);
      return seed[15:8];
   endfunction

   function automatic logic [7:0] ep(input logic c, h, v, input logic [7:0] p, q);
      return {c, h, p[5:3], v, p[1], ^q};
   endfunction

   function automatic logic [7:0] bcd(input int v);
      return {4'(v / 10 % 10), 4'(v % 10)};
   endfunction

   task automatic chk(input logic [31:0] g, e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic complete_run();
      $display("checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // One request cycle, cleared at the next rising edge, then back at the falling edge
   task automatic drv(input logic w, r, input logic [7:0] a, d, input csr_op_t o,
                      input logic [7:0] od, input logic bw, input logic [2:0] bs,
                      input logic bv);
      @(posedge clk_i);
      wr_i <= w;
      rd_i <= r;
      addr_i <= a;
      wdata_i <= d;
      op_i <= o;
      opnd_i <= od;
      bit_we_i <= bw;
      bit_sel_i <= bs;
      bit_val_i <= bv;
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      op_i <= CSR_OP_NONE;
      bit_we_i <= 1'b0;
      @(negedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, d);
      drv(1, 0, a, d, CSR_OP_NONE, 8'h00, 0, 3'h0, 0);
   endtask

   task automatic rd(input logic [7:0] a, e);
      exp_q.push_back(e);
      drv(0, 1, a, 8'h00, CSR_OP_NONE, 8'h00, 0, 3'h0, 0);
   endtask

   task automatic op(input csr_op_t o, input logic [7:0] d);
      drv(0, 0, 8'h00, 8'h00, o, d, 0, 3'h0, 0);
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge clk_i) rd_pend <= rd_i;
   always @(negedge clk_i) begin
      if (rd_pend === 1'b1)
         chk({24'h0, rdata_o}, {24'h0, exp_q.pop_front()});
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      complete_run();
   end

   initial begin
      logic [7:0] a, b, p, r;
      logic [8:0] s;
      logic c, h, v;
      logic [15:0] m;
      csr_op_t o;
      int x, y;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      for (int i = 0; i < 8; i++) rd(ra[i], i == 2 ? RST_STACK : RST_ZERO);
      op(CSR_OP_PUSH, 8'h5a);
      chk({7'h0, stack_we_o, stack_addr_o, stack_pointer_o, stack_wdata_o}, 32'h0108_085a);
      wr(ADDR_STACK, 8'hff);
      op(CSR_OP_PUSH, 8'ha5);
      chk({7'h0, stack_we_o, stack_addr_o, stack_pointer_o, stack_wdata_o}, 32'h0100_00a5);
      op(CSR_OP_POP, 8'h00);
      chk({23'h0, stack_we_o, stack_pointer_o}, 32'h0000_00ff);
      for (int i = 0; i < 6; i++) begin
         p = rnd();
         if (i == 0) r = p;
         wr(ra[i], p);
         rd(ra[i], i == 5 ? {p[7:1], ^r} : p);
      end
      wr(8'h90, rnd());
      rd(8'h90, 8'h00);
      for (int n = 0; n < 4; n++) begin
         wr(ADDR_STATUS, 8'(n * 8) | 8'h20);
         rd(ADDR_STATUS, 8'(n * 8) | 8'h20 | {7'h00, ^r});
         for (int i = 0; i < 8; i++) begin
            @(posedge clk_i) work_reg_i <= 3'(i);
            @(negedge clk_i);
            chk({24'h0, work_reg_addr_o}, 32'(n * 8 + i));
         end
      end
      for (int i = 0; i < 8; i++) begin
         b = rnd();
         drv(0, 0, 8'h00, 8'h00, CSR_OP_NONE, 8'h00, 1, 3'(i), b[0]);
         r[i] = b[0];
         chk({23'h0, acc_bit_o, acc_o}, {23'h0, b[0], r});
      end
      for (int k = 0; k < 18; k++) begin
         o = k % 3 == 0 ? CSR_OP_ADD : k % 3 == 1 ? CSR_OP_ADDC : CSR_OP_SUBB;
         a = k < 3 ? 8'h7f : rnd();
         b = k < 3 ? 8'h01 : rnd();
         p = rnd();
         wr(ADDR_ACC, a);
         wr(ADDR_STATUS, p);
         op(o, b);
         c = o == CSR_OP_ADD ? 1'b0 : p[7];
         if (o == CSR_OP_SUBB) begin
            s = {1'b0, a} - {1'b0, b} - c;
            h = int'(a[3:0]) < int'(b[3:0]) + int'(c);
            v = (a[7] ^ b[7]) & (s[7] ^ a[7]);
         end else begin
            s = {1'b0, a} + {1'b0, b} + c;
            h = int'(a[3:0]) + int'(b[3:0]) + int'(c) > 15;
            v = (a[7] == b[7]) & (s[7] != a[7]);
         end
         chk({16'h0, acc_o, program_status_word_o}, {16'h0, s[7:0], ep(s[8], h, v, p, s[7:0])});
      end
      for (int k = 0; k < 8; k++) begin
         a = k == 1 ? 8'h0f : k == 3 ? 8'h10 : rnd();
         b = k == 0 ? 8'h00 : k == 1 ? 8'h11 : k == 3 ? 8'h10 : rnd();
         p = rnd() | 8'h80;
         wr(ADDR_ACC, a);
         wr(ADDR_MULDIV, b);
         wr(ADDR_STATUS, p);
         op(k % 2 ? CSR_OP_MUL : CSR_OP_DIV, 8'h00);
         if (k % 2) begin
            m = a * b;
            v = m > 16'h00ff;
         end else begin
            m = b == 0 ? 16'h0000 : {a % b, a / b};
            v = b == 0;
         end
         chk({acc_o, sec_o, program_status_word_o}, {m[7:0], m[15:8], ep(0, p[6], v, p, m[7:0])});
      end
      for (int k = 0; k < 6; k++) begin
         x = k == 0 ? 99 : k == 1 ? 50 : rnd() % 100;
         y = k == 0 ? 1 : k == 1 ? 49 : rnd() % 100;
         wr(ADDR_STATUS, 8'h00);
         wr(ADDR_ACC, bcd(x));
         op(CSR_OP_ADD, bcd(y));
         op(CSR_OP_DA, 8'h00);
         chk({23'h0, program_status_word_o[BIT_CARRY], acc_o}, {23'h0, x + y > 99, bcd(x + y)});
      end
      for (int k = 0; k < 4; k++) begin
         a = rnd();
         b = k == 0 ? a : rnd();
         wr(ADDR_ACC, a);
         op(CSR_OP_CJNE, b);
         chk({23'h0, program_status_word_o[BIT_CARRY], acc_o}, {23'h0, a < b, a});
      end
      a = rnd();
      b = rnd();
      m = {rnd(), rnd()};
      wr(ADDR_AUX, 8'h00);
      wr(ADDR_PTR_LO, a);
      wr(ADDR_PTR_HI, b);
      chk({16'h0, data_pointer_o}, {16'h0, b, a});
      wr(ADDR_AUX, 8'h01);
      rd(ADDR_AUX, 8'h01);
      chk({16'h0, data_pointer_o}, 32'h0000_0000);
      wr(ADDR_PTR_LO, m[7:0]);
      wr(ADDR_PTR_HI, m[15:8]);
      chk({16'h0, data_pointer_o}, {16'h0, m});
      rd(ADDR_PTR_LO, m[7:0]);
      wr(ADDR_AUX, 8'h00);
      chk({16'h0, data_pointer_o}, {16'h0, b, a});
      rd(ADDR_PTR_HI, b);
      repeat (2) @(negedge clk_i);
      complete_run();
   end
endmodule
`default_nettype wire
